// ### rtl/pocfg_top.v
/*
 * Pulse output and phase calibration configuration bank, APB slave.
 * Assumes converter events and energy values come from the metering datapath
 * synchronous to mclk, and an APB master clocked by mclk.
 */
// The implementer's own choice: the APB slave port.
`timescale 1ns/1ps
`include "pocfg_defs.vh"

module pocfg_top
#(
    parameter ENERGY_W = 32
)
(
    input wire mclk,
    input wire sys_rst,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [31:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    input wire [2:0] conv_pulse,
    input wire [ENERGY_W-1:0] energy_in,
    output reg pulse_out_one,
    output reg pulse_out_two,
    output reg pulse_out_three,
    output reg [2:0] pulse_quantity_valid,
    output reg [8:0] pulse_sel_q,
    output reg [8:0] pulse_phase_mask_q,
    output reg [ENERGY_W-1:0] energy_latched_one,
    output reg [ENERGY_W-1:0] energy_latched_two,
    output reg [ENERGY_W-1:0] energy_latched_three,
    output reg [2:0] energy_latch_done,
    output reg [2:0] phase_to_voltage,
    output reg [26:0] phase_comp_amount
);
    localparam ST_IDLE = 2'b01;
    localparam ST_ACCESS = 2'b10;

    reg [15:0] pulse_output_config_reg;
    reg [15:0] computation_mode_register_reg;
    reg [15:0] cal_reg [0:2];
    reg [1:0] state_reg;
    reg [1:0] state_next;
    reg [15:0] rd_next;
    reg addr_ok;
    reg [2:0] sel_ok;
    wire [2:0] gate;
    wire [2:0] capture;
    wire [2:0] volt_w;
    wire [26:0] amt_w;
    integer i;

    function [15:0] idx_of;
        input [31:0] a;
        begin
            idx_of = a[17:2];
        end
    endfunction

    // Reserved select codes 101..111 carry no quantity
    function sel_valid;
        input [2:0] s;
        begin
            sel_valid = (s <= `POCFG_Q_FUND_REACTIVE);
        end
    endfunction

    wire [2:0] sel1 = pulse_output_config_reg[`POCFG_SEL1_LSB +: 3];
    wire [2:0] sel2 = pulse_output_config_reg[`POCFG_SEL2_LSB +: 3];
    wire [2:0] sel3 = pulse_output_config_reg[`POCFG_SEL3_LSB +: 3];
    assign gate = pulse_output_config_reg[`POCFG_GATE_LSB +: 3];
    assign capture = pulse_output_config_reg[`POCFG_CAPT_LSB +: 3];

    // Zero-wait-state slave: one setup, one access cycle
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~addr_ok;

    always @*
    begin
        addr_ok = 1'b1;
        rd_next = 16'h0000;
        case (idx_of(paddr))
            `POCFG_IDX_PULSE_CFG: rd_next = pulse_output_config_reg;
            `POCFG_IDX_COMP_MODE: rd_next = computation_mode_register_reg;
            `POCFG_IDX_PHASE_A: rd_next = cal_reg[0];
            `POCFG_IDX_PHASE_B: rd_next = cal_reg[1];
            `POCFG_IDX_PHASE_C: rd_next = cal_reg[2];
            default: addr_ok = 1'b0;
        endcase
        if (paddr[1:0] != 2'b00 || paddr[31:18] != 14'h0000)
        begin
            addr_ok = 1'b0;
            rd_next = 16'h0000;
        end
    end

    always @*
    begin
        case (state_reg)
            ST_IDLE: state_next = (psel && !penable) ? ST_ACCESS : ST_IDLE;
            ST_ACCESS: state_next = (psel && !penable) ? ST_ACCESS : ST_IDLE;
            default: state_next = ST_IDLE;
        endcase
    end

    always @(posedge mclk)
    begin
        if (sys_rst)
        begin
            state_reg <= ST_IDLE;
            prdata <= 32'h00000000;
            pulse_output_config_reg <= `POCFG_PULSE_CFG_RST;
            computation_mode_register_reg <= `POCFG_COMP_MODE_RST;
            for (i = 0; i < 3; i = i + 1)
                cal_reg[i] <= `POCFG_CAL_RST;
        end
        else
        begin
            state_reg <= state_next;
            if (psel && !penable)
                prdata <= {16'h0000, rd_next};
            if (state_reg == ST_ACCESS && psel && penable && pwrite && addr_ok)
            begin
                case (idx_of(paddr))
                    `POCFG_IDX_PULSE_CFG:
                        pulse_output_config_reg <= pwdata[15:0] & `POCFG_PULSE_CFG_MASK;
                    `POCFG_IDX_COMP_MODE:
                        computation_mode_register_reg <= pwdata[15:0];
                    `POCFG_IDX_PHASE_A:
                        cal_reg[0] <= pwdata[15:0] & `POCFG_CAL_MASK;
                    `POCFG_IDX_PHASE_B:
                        cal_reg[1] <= pwdata[15:0] & `POCFG_CAL_MASK;
                    `POCFG_IDX_PHASE_C:
                        cal_reg[2] <= pwdata[15:0] & `POCFG_CAL_MASK;
                    default:
                        pulse_output_config_reg <= pulse_output_config_reg;
                endcase
            end
        end
    end

    // Configuration presented to the converter datapath
    always @(posedge mclk)
    begin
        if (sys_rst)
        begin
            pulse_sel_q <= 9'h088;
            pulse_phase_mask_q <= 9'h1ff;
            pulse_quantity_valid <= 3'b111;
        end
        else
        begin
            pulse_sel_q <= {sel3, sel2, sel1};
            pulse_phase_mask_q <= computation_mode_register_reg[8:0];
            pulse_quantity_valid <= {sel_valid(sel3), sel_valid(sel2),
                sel_valid(sel1)};
        end
    end

    // Pins follow converter events unless gated or the code is reserved
    always @(posedge mclk)
    begin
        if (sys_rst)
        begin
            pulse_out_one <= 1'b0;
            pulse_out_two <= 1'b0;
            pulse_out_three <= 1'b0;
            energy_latched_one <= {ENERGY_W{1'b0}};
            energy_latched_two <= {ENERGY_W{1'b0}};
            energy_latched_three <= {ENERGY_W{1'b0}};
            energy_latch_done <= 3'b000;
        end
        else
        begin
            pulse_out_one <= conv_pulse[0] & ~gate[0] & sel_valid(sel1);
            pulse_out_two <= conv_pulse[1] & ~gate[1] & sel_valid(sel2);
            pulse_out_three <= conv_pulse[2] & ~gate[2] & sel_valid(sel3);
            // Capture runs on the converter event, even with the pin gated
            energy_latch_done <= conv_pulse & capture & {sel_valid(sel3),
                sel_valid(sel2), sel_valid(sel1)};
            if (conv_pulse[0] && capture[0] && sel_valid(sel1))
                energy_latched_one <= energy_in;
            if (conv_pulse[1] && capture[1] && sel_valid(sel2))
                energy_latched_two <= energy_in;
            if (conv_pulse[2] && capture[2] && sel_valid(sel3))
                energy_latched_three <= energy_in;
        end
    end

    genvar g;
    generate
        for (g = 0; g < 3; g = g + 1)
        begin : cal_dec
            pocfg_cal_decode u_dec
            (
                .phase_comp_value(cal_reg[g][9:0]),
                .to_voltage(volt_w[g]),
                .comp_amount(amt_w[g*9 +: 9])
            );
        end
    endgenerate

    always @(posedge mclk)
    begin
        if (sys_rst)
        begin
            phase_to_voltage <= 3'b000;
            phase_comp_amount <= 27'h0000000;
        end
        else
        begin
            phase_to_voltage <= volt_w;
            phase_comp_amount <= amt_w;
        end
    end
endmodule

// ### rtl/pocfg_defs.vh
`ifndef POCFG_DEFS_VH
`define POCFG_DEFS_VH

// Printed offsets (register index; byte address is index * 4)
`define POCFG_IDX_PULSE_CFG 16'he610
`define POCFG_IDX_PHASE_A 16'he614
`define POCFG_IDX_PHASE_B 16'he615
`define POCFG_IDX_PHASE_C 16'he616
`define POCFG_IDX_COMP_MODE 16'he60e

// Pulse configuration fields
`define POCFG_SEL1_LSB 0
`define POCFG_SEL2_LSB 3
`define POCFG_SEL3_LSB 6
`define POCFG_GATE_LSB 9
`define POCFG_CAPT_LSB 12
`define POCFG_PULSE_CFG_MASK 16'h7fff
`define POCFG_PULSE_CFG_RST 16'h0e88

// Computation mode: three phase masks in bits 8:0, rest stored as written
`define POCFG_COMP_MODE_RST 16'h01ff

// Calibration fields
`define POCFG_CAL_MASK 16'h03ff
`define POCFG_CAL_RST 16'h0000
`define POCFG_CAL_VOLT_BIT 9
`define POCFG_CAL_ALIAS_BIT 8
`define POCFG_CAL_ALIAS_MIN 7'h40

// Quantity codes
`define POCFG_Q_TOTAL_ACTIVE 3'h0
`define POCFG_Q_TOTAL_REACTIVE 3'h1
`define POCFG_Q_APPARENT 3'h2
`define POCFG_Q_FUND_ACTIVE 3'h3
`define POCFG_Q_FUND_REACTIVE 3'h4

`endif

// ### rtl/pocfg_cal_decode.v
/*
 * Decodes one phase compensation value into target channel and amount.
 * Assumes the value is the stored 10-bit field; purely combinational.
 */
`timescale 1ns/1ps
`include "pocfg_defs.vh"

module pocfg_cal_decode
(
    input wire [9:0] phase_comp_value,
    output reg to_voltage,
    output reg [8:0] comp_amount
)
;
    always @*
    begin
        to_voltage = phase_comp_value[`POCFG_CAL_VOLT_BIT];
        comp_amount = {1'b0, phase_comp_value[7:0]};
        if (phase_comp_value[`POCFG_CAL_ALIAS_BIT]
            && phase_comp_value[7:1] < `POCFG_CAL_ALIAS_MIN)
        begin
            comp_amount = {1'b1, phase_comp_value[7:0]};
        end
        else if (phase_comp_value[`POCFG_CAL_ALIAS_BIT])
        begin
            // 384..511 and 896..1023 fold onto the first 128 codes
            comp_amount = {2'b00, phase_comp_value[6:0]};
        end
    end
endmodule

// ### sim/pocfg_props.sv
/* Port checks for pocfg_top.
   Assumes one clock, mclk, and synchronous active-high sys_rst. */
`timescale 1ns/1ps
module pocfg_props
#(
    parameter ENERGY_W = 32
)
(
    input logic mclk,
    input logic sys_rst,
    input logic psel,
    input logic penable,
    input logic [31:0] paddr,
    input logic pready,
    input logic pslverr,
    input logic [2:0] conv_pulse,
    input logic [ENERGY_W-1:0] energy_in,
    input logic pulse_out_one,
    input logic [2:0] pulse_quantity_valid,
    input logic [8:0] pulse_sel_q,
    input logic [8:0] pulse_phase_mask_q,
    input logic [ENERGY_W-1:0] energy_latched_one,
    input logic [2:0] energy_latch_done,
    input logic [26:0] phase_comp_amount
);
default clocking cb @(posedge mclk); endclocking
default disable iff (sys_rst);
sequence rsv_pulse_s;
    conv_pulse[0] && pulse_sel_q[2:0] > 3'h4 ##1 pulse_sel_q[2:0] > 3'h4;
endsequence
AST_RDY: assert property (psel && penable |-> pready)
    else $error("access phase without ready");
AST_MISALIGN: assert property (psel && penable && paddr[1:0] != 2'h0 |-> pslverr)
    else $error("misaligned access not refused");
AST_MAPPED: assert property (psel && penable && paddr == 32'h00039840 |-> !pslverr)
    else $error("mapped access refused");
AST_VALID1: assert property (pulse_quantity_valid[0] == (pulse_sel_q[2:0] <= 3'h4))
    else $error("channel one validity wrong");
AST_VALID3: assert property (pulse_quantity_valid[2] == (pulse_sel_q[8:6] <= 3'h4))
    else $error("channel three validity wrong");
AST_PIN: assert property (pulse_out_one |-> $past(conv_pulse[0]))
    else $error("pin pulse without converter event");
AST_RSV: assert property (rsv_pulse_s |-> !pulse_out_one && !energy_latch_done[0])
    else $error("reserved code still pulses");
AST_LATCH: assert property (energy_latch_done[0] |->
    $past(conv_pulse[0]) && energy_latched_one == $past(energy_in))
    else $error("latched energy wrong");
AST_FOLD: assert property (phase_comp_amount[8:0] < 9'h180 &&
    phase_comp_amount[17:9] < 9'h180 && phase_comp_amount[26:18] < 9'h180)
    else $error("compensation amount not folded");
AST_RST: assert property ($fell(sys_rst) |->
    pulse_sel_q == 9'h088 && pulse_phase_mask_q == 9'h1ff)
    else $error("reset selects or masks wrong");
endmodule
bind pocfg_top pocfg_props #(.ENERGY_W(ENERGY_W)) i_props (.mclk(mclk), .sys_rst(sys_rst),
    .psel(psel), .penable(penable), .paddr(paddr), .pready(pready), .pslverr(pslverr),
    .conv_pulse(conv_pulse), .energy_in(energy_in), .pulse_out_one(pulse_out_one),
    .pulse_quantity_valid(pulse_quantity_valid), .pulse_sel_q(pulse_sel_q),
    .pulse_phase_mask_q(pulse_phase_mask_q), .energy_latched_one(energy_latched_one),
    .energy_latch_done(energy_latch_done), .phase_comp_amount(phase_comp_amount));

// ### sim/pulse_output_and_phase_cal_config_bench.sv
/* Self-checking bench for pocfg_top.
   Assumes an APB slave on mclk and one-cycle converter events. */
`timescale 1ns/1ps
`include "pocfg_defs.vh"
module pulse_output_and_phase_cal_config_bench;
logic mclk, sys_rst, psel, penable, pwrite, pready, pslverr, se;
logic [31:0] paddr, pwdata, prdata, rd, rnd, d, e, el1, el2, el3, energy_in;
logic [2:0] conv_pulse, pulse_quantity_valid, energy_latch_done, phase_to_voltage;
wire [2:0] po;
logic [8:0] pulse_sel_q, pulse_phase_mask_q;
logic [26:0] phase_comp_amount;
logic [15:0] idx [5] = '{`POCFG_IDX_PULSE_CFG, `POCFG_IDX_COMP_MODE, `POCFG_IDX_PHASE_A,
    `POCFG_IDX_PHASE_B, `POCFG_IDX_PHASE_C};
logic [31:0] msk [5] = '{32'h7fff, 32'hffff, 32'h3ff, 32'h3ff, 32'h3ff};
logic [31:0] rstv [5] = '{32'h0e88, 32'h01ff, 32'h0, 32'h0, 32'h0};
logic [31:0] cv [7] = '{32'h17f, 32'h180, 32'h1ff, 32'h200, 32'h37f, 32'h380, 32'h3ff};
integer n_errors = 0, total_checks = 0, i, n, c, r;
pocfg_top i_dut (.mclk(mclk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .conv_pulse(conv_pulse), .energy_in(energy_in),
    .pulse_out_one(po[0]), .pulse_out_two(po[1]), .pulse_out_three(po[2]),
    .pulse_quantity_valid(pulse_quantity_valid), .pulse_sel_q(pulse_sel_q),
    .pulse_phase_mask_q(pulse_phase_mask_q), .energy_latched_one(el1),
    .energy_latched_two(el2), .energy_latched_three(el3),
    .energy_latch_done(energy_latch_done), .phase_to_voltage(phase_to_voltage),
    .phase_comp_amount(phase_comp_amount));
function logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    xs = s ^ (s << 5);
endfunction
// Expected {to_voltage, amount}: top quarter of each half folds down
function logic [9:0] fold(input logic [9:0] v);
    fold = {v[9], (v[8:7] == 2'b11) ? 2'b00 : v[8:7], v[6:0]};
endfunction
task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks = total_checks + 1;
    if (got !== exp)
    begin
        n_errors = n_errors + 1;
        $display("BAD %0t got %h expected %h", $time, got, exp);
    end
endtask
task apb(input logic w, input logic [31:0] a, input logic [31:0] wd);
    integer k;
    k = 0;
    @(posedge mclk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= wd;
    @(posedge mclk);
    penable <= 1'b1;
    do
    begin
        @(posedge mclk);
        k = k + 1;
    end while (pready !== 1'b1 && k < 20);
    rd = prdata;
    se = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    if (k >= 20) chk(0, 1);
endtask
task give_verdict;
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
        $display("[ PASS ]");
    else
        $display("[ FAIL ]");
    $finish;
endtask
initial
begin
    mclk = 0;
    forever #20 mclk = ~mclk;
end
initial
begin
    repeat (20000) @(posedge mclk);
    n_errors = n_errors + 1;
    give_verdict;
end
initial
begin
    sys_rst = 1; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
    conv_pulse = 0; energy_in = 0; rnd = 32'h00843411;
    repeat (5) @(posedge mclk);
    sys_rst <= 1'b0;
    for (r = 0; r < 5; r++)
    begin
        apb(0, {14'h0, idx[r], 2'b00}, 0);
        chk(rd, rstv[r]);
    end
    $display("reset values done");
    for (i = 0; i < 40; i++)
    begin
        rnd = xs(rnd);
        r = (i < 7) ? 2 + i % 3 : rnd[10:8] % 5;
        d = (i < 7) ? (cv[i] | (rnd & 32'hfffffc00)) : xs(rnd);
        apb(1, {14'h0, idx[r], 2'b00}, d);
        apb(0, {14'h0, idx[r], 2'b00}, 0);
        chk(rd, d & msk[r]);
        if (r >= 2) chk({phase_to_voltage[r-2], phase_comp_amount[(r-2)*9 +: 9]}, fold(d[9:0]));
        if (r == 1) chk(pulse_phase_mask_q, d[8:0]);
        if (r == 0) chk(pulse_sel_q, d[8:0]);
    end
    apb(0, 32'h00039844, 0);
    chk(se, 1);
    chk(rd, 0);
    apb(1, 32'h00039842, 32'h0);
    chk(se, 1);
    $display("register access done");
    apb(1, {14'h0, idx[1], 2'b00}, 32'h01ff);
    for (n = 0; n < 3; n++)
        for (c = 0; c < 16; c++)
        begin
            d = 32'h8000 | (c[2:0] << (3 * n)) | (c[3] ? (32'h1200 << n) : 0);
            apb(1, {14'h0, idx[0], 2'b00}, d);
            rnd = xs(rnd);
            e = rnd;
            @(posedge mclk);
            conv_pulse <= 3'h1 << n;
            energy_in <= e;
            @(posedge mclk);
            conv_pulse <= 3'h0;
            #1;
            chk(po[n], c[2:0] <= 3'h4 && !c[3]);
            chk(energy_latch_done[n], c[2:0] <= 3'h4 && c[3]);
            chk(pulse_quantity_valid[n], c[2:0] <= 3'h4);
            if (c[2:0] <= 3'h4 && c[3]) chk(n == 0 ? el1 : n == 1 ? el2 : el3, e);
        end
    $display("pulse channels done");
    give_verdict;
end
endmodule
